// ---- pkg/step_ctrl_pkg.sv ----
// Constants, register map and shared arithmetic of the closed-loop step control block
package step_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam int GAIN_W = 16;
    localparam int MAG_W = 31;
    localparam int MSTEP_W = 8;
    localparam int VENC_FRAC = 6;
    localparam int ENC_FRAC = 16;
    localparam int ENC_ACC_W = 48;
    localparam int FOLLOW_W = 15;
    localparam int GAIN_FRAC = 8;
    localparam int INT_DIV = 128;
    localparam int INT_CNT_W = 7;
    localparam int CTRL_W = 4;
    localparam int CLK_HZ = 40000000;
    localparam int PID_RATE_HZ = 100000;
    localparam logic [GAIN_W-1:0] PID_DIV_RST = GAIN_W'(CLK_HZ / PID_RATE_HZ - 1);
    localparam logic [INT_CNT_W-1:0] INT_LAST = INT_CNT_W'(INT_DIV - 1);
    // Control bits
    localparam int CTRL_PID_EN = 0;
    localparam int CTRL_VECTOR_EN = 1;
    localparam int CTRL_FOLLOW_EN = 2;
    localparam int CTRL_FOLLOW_NEG = 3;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] PID_P_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] PID_I_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] PID_D_OFS = 12'h00C;
    localparam logic [ADDR_W-1:0] ICLIP_OFS = 12'h010;
    localparam logic [ADDR_W-1:0] TOL_OFS = 12'h014;
    localparam logic [ADDR_W-1:0] PID_DIV_OFS = 12'h018;
    localparam logic [ADDR_W-1:0] VCLIP_OFS = 12'h01C;
    localparam logic [ADDR_W-1:0] SW_OFS_OFS = 12'h020;
    localparam logic [ADDR_W-1:0] ENC_SCALE_OFS = 12'h024;
    localparam logic [ADDR_W-1:0] VENC_SCALE_OFS = 12'h028;
    localparam logic [ADDR_W-1:0] VENC_POS_OFS = 12'h02C;
    localparam logic [ADDR_W-1:0] ANGLE_LIM_OFS = 12'h030;
    localparam logic [ADDR_W-1:0] XDIV_OFS = 12'h034;
    localparam logic [ADDR_W-1:0] XTHR_OFS = 12'h038;
    localparam logic [ADDR_W-1:0] FSCALE_OFS = 12'h03C;
    localparam logic [ADDR_W-1:0] ENC_POS_OFS = 12'h040;
    localparam logic [ADDR_W-1:0] SEQ_POS_OFS = 12'h044;
    localparam logic [ADDR_W-1:0] ERR_OFS = 12'h048;
    localparam logic [ADDR_W-1:0] VEL_OFS = 12'h04C;
    localparam logic [ADDR_W-1:0] CLIP_OFS = 12'h050;
    localparam logic [ADDR_W-1:0] ISUM_OFS = 12'h054;
    localparam logic [ADDR_W-1:0] MSTEP_OFS = 12'h058;
    // Reset values
    localparam logic [31:0] ENC_SCALE_RST = 32'h0001_0000;
    localparam logic [GAIN_W-1:0] VENC_SCALE_RST = 16'h0040;
    localparam logic [MSTEP_W-1:0] ANGLE_LIM_RST = 8'h40;
    localparam logic [GAIN_W-1:0] XDIV_RST = 16'h0040;
    localparam logic [MAG_W-1:0] MAG_MAX = 31'h7FFF_FFFF;

    function automatic logic signed [63:0] clamp64(input logic signed [63:0] x,
                                                   input logic [MAG_W-1:0] lim);
        logic signed [63:0] l;
        l = $signed({33'h0, lim});
        if (x > l) clamp64 = l;
        else if (x < -l) clamp64 = -l;
        else clamp64 = x;
    endfunction

    function automatic logic [31:0] mag32(input logic signed [31:0] x);
        mag32 = x[31] ? 32'(-x) : 32'(x);
    endfunction
endpackage

// ---- pkg/pid_link_if.sv ----
// Parameter and result bundle between the top and the regulator
`timescale 1ns/10ps
interface pid_link_if;
    import step_ctrl_pkg::*;
    logic en;
    logic upd_tick;
    logic int_tick;
    logic signed [31:0] err;
    logic [GAIN_W-1:0] p, i, d, tol;
    logic [MAG_W-1:0] iclip, vclip;
    logic signed [31:0] offset;
    logic signed [31:0] vel, clip, isum;
    modport top (output en, upd_tick, int_tick, err, p, i, d, tol, iclip, vclip, offset,
                 input vel, clip, isum);
    modport pid (input en, upd_tick, int_tick, err, p, i, d, tol, iclip, vclip, offset,
                 output vel, clip, isum);
endinterface

// ---- hdl/pid_regulator.sv ----
// Velocity regulator with clipped integral, error tolerance band and clip report
`timescale 1ns/10ps
module pid_regulator
    import step_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Regulator link
    pid_link_if.pid lnk
);
    logic signed [31:0] isum_r, eprev_r, vel_r, clip_r;
    logic signed [63:0] e64, iinc, pterm, dterm, raw, lim;
    logic outside;

    always_comb begin
        e64 = 64'(lnk.err);
        outside = mag32(lnk.err) > {16'h0000, lnk.tol};
        iinc = (e64 * $signed({48'h0, lnk.i})) >>> GAIN_FRAC;
        pterm = (e64 * $signed({48'h0, lnk.p})) >>> GAIN_FRAC;
        dterm = (64'(lnk.err - eprev_r) * $signed({48'h0, lnk.d})) >>> GAIN_FRAC;
        raw = 64'(lnk.offset);
        if (outside) raw = pterm + 64'(isum_r) + dterm + 64'(lnk.offset);
        lim = clamp64(raw, lnk.vclip);
    end

    // Integral runs on its own fixed tick, while the error stands outside tolerance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) isum_r <= '0;
        else if (!lnk.en) isum_r <= '0;
        else if (lnk.int_tick && outside) begin
            isum_r <= 32'(clamp64(64'(isum_r) + iinc, lnk.iclip));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eprev_r <= '0;
            vel_r <= '0;
            clip_r <= '0;
        end else if (!lnk.en) begin
            eprev_r <= lnk.err;
            vel_r <= '0;
            clip_r <= '0;
        end else if (lnk.upd_tick) begin
            eprev_r <= lnk.err;
            vel_r <= 32'(lim);
            clip_r <= 32'(clamp64(raw - lim, MAG_MAX));
        end
    end

    assign lnk.vel = vel_r;
    assign lnk.clip = clip_r;
    assign lnk.isum = isum_r;
endmodule

// ---- hdl/step_pulse_out.sv ----
// Step, direction and extended step pin formatting
`timescale 1ns/10ps
module step_pulse_out
    import step_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Motion events
    input wire logic mv,
    input wire logic mdir,
    input wire logic fast,
    input wire logic [GAIN_W-1:0] xdiv,
    // Pins
    output logic step_o,
    output logic dir_o,
    output logic xstep_o
);
    logic [GAIN_W-1:0] xcnt_r, xcnt_nxt;
    logic wrap;

    always_comb begin
        xcnt_nxt = xcnt_r + 16'h0001;
        wrap = xcnt_nxt >= xdiv;
    end

    // Microsteps are counted in any direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) xcnt_r <= '0;
        else if (mv) xcnt_r <= wrap ? '0 : xcnt_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_o <= 1'b0;
            dir_o <= 1'b0;
            xstep_o <= 1'b0;
        end else begin
            step_o <= mv && !fast;
            xstep_o <= mv && fast && wrap;
            if (mv) dir_o <= mdir;
        end
    end
endmodule

// ---- hdl/closed_loop_step_control.sv ----
// Closed-loop step control top: APB registers, encoder, vector limit, follower, stepping
//
// Overview of operation
// - Error is encoder position minus sequencer position.
// - Velocity sums P, I, D terms outside tolerance.
// - Zero D gives PI, zero I gives P.
// - Software velocity offset adds into output.
// - Readable clip amount of regulator output.
// - Integral grows by I times error, clipped.
// - Integration runs at clock over 128.
// - Derivative time base from programmable divider.
// - Position error readable at any time.
// - Programmable regulator update rate, about 100kHz.
// - Vector encoder scale is binary fraction only.
// - Load angle limit accepts above 90 degrees.
// - Microstep address zero at reset; sequencer position read-only.
// - Steps up to clock rate with direction.
// - Extended pulse marks a divided group of steps.
// - Threshold picks step or extended step output.
// - Follower moves by scaled signed input steps.
// - Step input sampled per clock, max half.
// - Encoder adds 16.16 scale per quadrature change.
`timescale 1ns/10ps
module closed_loop_step_control
    import step_ctrl_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Quadrature encoder
    input wire logic enc_a,
    input wire logic enc_b,
    // Follower step and direction input
    input wire logic step_in,
    input wire logic dir_in,
    // Step and direction output
    output logic step_out,
    output logic dir_out,
    output logic xstep_out
);
    pid_link_if lnk();

    logic [CTRL_W-1:0] ctrl_r;
    logic [GAIN_W-1:0] pid_p_r, pid_i_r, pid_d_r, tol_r, pid_div_r;
    logic [MAG_W-1:0] iclip_r, vclip_r, xthr_r;
    logic signed [31:0] software_velocity_offset_r;
    logic [31:0] enc_scale_r;
    logic [GAIN_W-1:0] vector_encoder_scale_r;
    logic [31:0] vector_encoder_microposition_r;
    logic [MSTEP_W-1:0] angle_lim_r;
    logic [GAIN_W-1:0] xdiv_r;
    logic [FOLLOW_W-1:0] follower_scale_factor_r;

    logic [ENC_ACC_W-1:0] enc_acc_r;
    logic signed [31:0] enc_x, x_actual_r, err_r;
    logic a_q_r, b_q_r, step_in_q_r;
    logic qchg, qup;

    logic [INT_CNT_W-1:0] int_cnt_r;
    logic [GAIN_W-1:0] upd_cnt_r;
    logic int_tick, upd_tick;

    logic [MAG_W-1:0] acc_r;
    logic [MAG_W:0] acc_sum;
    logic [31:0] vmag;
    logic vneg, vcarry, vstep, inhibit;
    logic signed [MSTEP_W:0] lead, lim9;

    logic [FOLLOW_W-1:0] facc_r;
    logic [FOLLOW_W:0] facc_sum;
    logic frise, fstep, fneg;
    logic mv, mdir, fast;

    logic setup, wr_en;
    logic [31:0] rd_nxt;
    logic err_nxt;

    // APB: answer one cycle after setup, access phase always one cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && err_nxt;
            prdata <= (setup && !pwrite) ? rd_nxt : '0;
        end
    end

    always_comb begin
        rd_nxt = '0;
        err_nxt = 1'b0;
        if (paddr == CTRL_OFS) rd_nxt = {28'h0, ctrl_r};
        else if (paddr == PID_P_OFS) rd_nxt = {16'h0, pid_p_r};
        else if (paddr == PID_I_OFS) rd_nxt = {16'h0, pid_i_r};
        else if (paddr == PID_D_OFS) rd_nxt = {16'h0, pid_d_r};
        else if (paddr == ICLIP_OFS) rd_nxt = {1'b0, iclip_r};
        else if (paddr == TOL_OFS) rd_nxt = {16'h0, tol_r};
        else if (paddr == PID_DIV_OFS) rd_nxt = {16'h0, pid_div_r};
        else if (paddr == VCLIP_OFS) rd_nxt = {1'b0, vclip_r};
        else if (paddr == SW_OFS_OFS) rd_nxt = software_velocity_offset_r;
        else if (paddr == ENC_SCALE_OFS) rd_nxt = enc_scale_r;
        else if (paddr == VENC_SCALE_OFS) rd_nxt = {16'h0, vector_encoder_scale_r};
        else if (paddr == VENC_POS_OFS) rd_nxt = vector_encoder_microposition_r;
        else if (paddr == ANGLE_LIM_OFS) rd_nxt = {24'h0, angle_lim_r};
        else if (paddr == XDIV_OFS) rd_nxt = {16'h0, xdiv_r};
        else if (paddr == XTHR_OFS) rd_nxt = {1'b0, xthr_r};
        else if (paddr == FSCALE_OFS) rd_nxt = {17'h0, follower_scale_factor_r};
        else if (paddr == ENC_POS_OFS) rd_nxt = enc_x;
        else if (paddr == SEQ_POS_OFS) rd_nxt = x_actual_r;
        else if (paddr == ERR_OFS) rd_nxt = err_r;
        else if (paddr == VEL_OFS) rd_nxt = lnk.vel;
        else if (paddr == CLIP_OFS) rd_nxt = lnk.clip;
        else if (paddr == ISUM_OFS) rd_nxt = lnk.isum;
        else if (paddr == MSTEP_OFS) rd_nxt = {24'h0, x_actual_r[MSTEP_W-1:0]};
        else err_nxt = 1'b1;
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            pid_p_r <= '0;
            pid_i_r <= '0;
            pid_d_r <= '0;
            iclip_r <= '0;
            tol_r <= '0;
            pid_div_r <= PID_DIV_RST;
            vclip_r <= MAG_MAX;
            software_velocity_offset_r <= '0;
            enc_scale_r <= ENC_SCALE_RST;
            vector_encoder_scale_r <= VENC_SCALE_RST;
            angle_lim_r <= ANGLE_LIM_RST;
            xdiv_r <= XDIV_RST;
            xthr_r <= MAG_MAX;
            follower_scale_factor_r <= '0;
        end else if (wr_en) begin
            if (paddr == CTRL_OFS) ctrl_r <= pwdata[CTRL_W-1:0];
            else if (paddr == PID_P_OFS) pid_p_r <= pwdata[GAIN_W-1:0];
            else if (paddr == PID_I_OFS) pid_i_r <= pwdata[GAIN_W-1:0];
            else if (paddr == PID_D_OFS) pid_d_r <= pwdata[GAIN_W-1:0];
            else if (paddr == ICLIP_OFS) iclip_r <= pwdata[MAG_W-1:0];
            else if (paddr == TOL_OFS) tol_r <= pwdata[GAIN_W-1:0];
            else if (paddr == PID_DIV_OFS) pid_div_r <= pwdata[GAIN_W-1:0];
            else if (paddr == VCLIP_OFS) vclip_r <= pwdata[MAG_W-1:0];
            else if (paddr == SW_OFS_OFS) software_velocity_offset_r <= pwdata;
            else if (paddr == ENC_SCALE_OFS) enc_scale_r <= pwdata;
            else if (paddr == VENC_SCALE_OFS) vector_encoder_scale_r <= pwdata[GAIN_W-1:0];
            else if (paddr == ANGLE_LIM_OFS) angle_lim_r <= pwdata[MSTEP_W-1:0];
            else if (paddr == XDIV_OFS) xdiv_r <= pwdata[GAIN_W-1:0];
            else if (paddr == XTHR_OFS) xthr_r <= pwdata[MAG_W-1:0];
            else if (paddr == FSCALE_OFS) follower_scale_factor_r <= pwdata[FOLLOW_W-1:0];
        end
    end

    // Quadrature decode; a double transition is a glitch and is dropped
    assign qchg = (enc_a ^ a_q_r) ^ (enc_b ^ b_q_r);
    assign qup = a_q_r ^ enc_b;
    assign enc_x = enc_acc_r[ENC_FRAC +: 32];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q_r <= 1'b0;
            b_q_r <= 1'b0;
        end else begin
            a_q_r <= enc_a;
            b_q_r <= enc_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) enc_acc_r <= '0;
        else if (qchg && qup) enc_acc_r <= enc_acc_r + {16'h0000, enc_scale_r};
        else if (qchg) enc_acc_r <= enc_acc_r - {16'h0000, enc_scale_r};
    end

    // A software write wins over an encoder step in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) vector_encoder_microposition_r <= '0;
        else if (wr_en && paddr == VENC_POS_OFS) vector_encoder_microposition_r <= pwdata;
        else if (qchg && qup) begin
            vector_encoder_microposition_r <=
                vector_encoder_microposition_r + {16'h0000, vector_encoder_scale_r};
        end else if (qchg) begin
            vector_encoder_microposition_r <=
                vector_encoder_microposition_r - {16'h0000, vector_encoder_scale_r};
        end
    end

    // Regulator time bases
    assign int_tick = int_cnt_r == INT_LAST;
    assign upd_tick = upd_cnt_r >= pid_div_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) int_cnt_r <= '0;
        else int_cnt_r <= int_cnt_r + 7'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) upd_cnt_r <= '0;
        else if (upd_tick) upd_cnt_r <= '0;
        else upd_cnt_r <= upd_cnt_r + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) err_r <= '0;
        else err_r <= enc_x - x_actual_r;
    end

    assign lnk.en = ctrl_r[CTRL_PID_EN];
    assign lnk.upd_tick = upd_tick;
    assign lnk.int_tick = int_tick;
    assign lnk.err = err_r;
    assign lnk.p = pid_p_r;
    assign lnk.i = pid_i_r;
    assign lnk.d = pid_d_r;
    assign lnk.tol = tol_r;
    assign lnk.iclip = iclip_r;
    assign lnk.vclip = vclip_r;
    assign lnk.offset = software_velocity_offset_r;

    pid_regulator u_pid (
        .pclk(pclk),
        .presetn(presetn),
        .lnk(lnk)
    );

    // Velocity to steps by phase accumulation; carry rate reaches the clock rate
    assign vneg = lnk.vel[31];
    assign vmag = mag32(lnk.vel);
    assign acc_sum = {1'b0, acc_r} + {1'b0, vmag[MAG_W-1:0]};
    assign vcarry = acc_sum[MAG_W] && ctrl_r[CTRL_PID_EN];

    // Lead of the sequencer over the measured rotor angle, one period per address wrap
    assign lead = $signed({1'b0, x_actual_r[MSTEP_W-1:0] -
                  vector_encoder_microposition_r[VENC_FRAC +: MSTEP_W]});
    assign lim9 = $signed({1'b0, angle_lim_r});

    always_comb begin
        logic signed [MSTEP_W:0] l8;
        l8 = lead;
        if (lead[MSTEP_W-1]) l8 = lead - $signed({1'b1, {MSTEP_W{1'b0}}});
        inhibit = ctrl_r[CTRL_VECTOR_EN] && (vneg ? (-l8 >= lim9) : (l8 >= lim9));
    end

    // A held step keeps its carry pending in the accumulator
    assign vstep = vcarry && !inhibit && !fstep;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) acc_r <= '0;
        else if (!ctrl_r[CTRL_PID_EN]) acc_r <= '0;
        else if (!vcarry || vstep) acc_r <= acc_sum[MAG_W-1:0];
    end

    // Follower input: scale below unity, so never faster than the master
    assign frise = step_in && !step_in_q_r;
    assign facc_sum = {1'b0, facc_r} + {1'b0, follower_scale_factor_r};
    assign fstep = frise && ctrl_r[CTRL_FOLLOW_EN] && facc_sum[FOLLOW_W];
    assign fneg = dir_in ^ ctrl_r[CTRL_FOLLOW_NEG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) step_in_q_r <= 1'b0;
        else step_in_q_r <= step_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) facc_r <= '0;
        else if (!ctrl_r[CTRL_FOLLOW_EN]) facc_r <= '0;
        else if (frise) facc_r <= facc_sum[FOLLOW_W-1:0];
    end

    // Sequencer position; follower step has priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) x_actual_r <= '0;
        else if (fstep) x_actual_r <= fneg ? x_actual_r - 32'sh1 : x_actual_r + 32'sh1;
        else if (vstep) x_actual_r <= vneg ? x_actual_r - 32'sh1 : x_actual_r + 32'sh1;
    end

    assign mv = fstep || vstep;
    assign mdir = fstep ? fneg : vneg;
    assign fast = vmag > {1'b0, xthr_r};

    step_pulse_out u_out (
        .pclk(pclk),
        .presetn(presetn),
        .mv(mv),
        .mdir(mdir),
        .fast(fast),
        .xdiv(xdiv_r),
        .step_o(step_out),
        .dir_o(dir_out),
        .xstep_o(xstep_out)
    );
endmodule

// ---- verif/closed_loop_step_control_sva.sv ----
// Protocol and stepping assertions for the closed-loop step control top
`timescale 1ns/10ps
module closed_loop_step_control_sva
    import step_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic step_in,
    input wire logic step_out,
    input wire logic xstep_out
);
    logic [CTRL_W-1:0] ctrl_r;
    logic step_in_r;
    logic [3:0] rise_age_r;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 4'h0;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
        end
    end
    // Saturates so a long idle input never looks recent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_in_r <= 1'b0;
            rise_age_r <= 4'hF;
        end else begin
            step_in_r <= step_in;
            if (step_in && !step_in_r) begin
                rise_age_r <= 4'h0;
            end else if (rise_age_r != 4'hF) begin
                rise_age_r <= rise_age_r + 4'h1;
            end
        end
    end
    a_ready_after_setup: assert property (psel && !penable |-> ##1 pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
        else $error("ready without setup");
    a_error_unmapped: assert property (pslverr |-> pready
        && (paddr > MSTEP_OFS || paddr[1:0] != 2'h0))
        else $error("error on mapped address");
    a_mapped_no_error: assert property (pready && paddr <= MSTEP_OFS
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_refused_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read returns data");
    a_one_pin_mode: assert property (step_out |-> !xstep_out)
        else $error("step and extended step together");
    a_follow_bound: assert property (step_out && !(ctrl_r[0] || $past(ctrl_r[0])
        || $past(ctrl_r[0], 2) || $past(ctrl_r[0], 3)) |-> rise_age_r <= 4'h3)
        else $error("follower step without master step");
    c_refused: cover property (pslverr);
    c_burst: cover property (step_out ##1 step_out);
    c_extended: cover property (xstep_out);
endmodule
bind closed_loop_step_control closed_loop_step_control_sva i_sva (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .step_in, .step_out,
    .xstep_out);

// ---- verif/axis_source_model.sv ----
// Quadrature encoder and master axis driving the block's input pins
`timescale 1ns/10ps
module axis_source_model (
    // Clock
    input wire logic pclk,
    // Encoder and master step pins
    output logic enc_a,
    output logic enc_b,
    output logic step_in,
    output logic dir_in
);
    logic [1:0] ph_r = 2'h0;
    initial begin
        {enc_a, enc_b, step_in, dir_in} = 4'h0;
    end
    // Phases 0..3 give AB 00,01,11,10 when counting up
    task automatic enc_move(input int n);
        repeat (n < 0 ? -n : n) begin
            @(posedge pclk);
            ph_r = n < 0 ? ph_r - 2'h1 : ph_r + 2'h1;
            enc_a <= ph_r[1];
            enc_b <= ph_r[1] ^ ph_r[0];
            repeat (2) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
    // Two clocks high, three low: below half the system clock
    task automatic master_steps(input int n, input logic dir);
        @(posedge pclk);
        dir_in <= dir;
        repeat (n) begin
            @(posedge pclk);
            step_in <= 1'b1;
            repeat (2) @(posedge pclk);
            step_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the closed-loop step control block
`timescale 1ns/10ps
module tb;
    import step_ctrl_pkg::*;
    localparam logic [ADDR_W-1:0] RST_A [9] = '{CTRL_OFS, PID_DIV_OFS, VCLIP_OFS,
        ENC_SCALE_OFS, VENC_SCALE_OFS, ANGLE_LIM_OFS, XDIV_OFS, XTHR_OFS, MSTEP_OFS};
    localparam logic [31:0] RST_V [9] = '{32'h0, 32'h18F, 32'h7FFF_FFFF, 32'h1_0000,
        32'h40, 32'h40, 32'h40, 32'h7FFF_FFFF, 32'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic enc_a, enc_b, step_in, dir_in, step_out, dir_out, xstep_out;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, v0;
    int miscompares = 0;
    int comparisons = 0;
    int steps = 0;
    int xsteps = 0;
    int d, ds, dx;
    closed_loop_step_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .enc_a, .enc_b, .step_in, .dir_in, .step_out,
        .dir_out, .xstep_out);
    axis_source_model i_src (.pclk, .enc_a, .enc_b, .step_in, .dir_in);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        steps <= steps + int'(step_out);
        xsteps <= xsteps + int'(xstep_out);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Setup one edge after entry, so back-to-back calls never drive twice at once
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic run();
        int s, x;
        logic [31:0] q;
        apb(1'b0, SEQ_POS_OFS, 32'h0);
        {q, s, x} = {rd, steps, xsteps};
        wr(CTRL_OFS, 32'h1);
        repeat (120) @(posedge pclk);
        wr(CTRL_OFS, 32'h0);
        repeat (5) @(posedge pclk);
        apb(1'b0, SEQ_POS_OFS, 32'h0);
        {d, ds, dx} = {int'(rd - q), steps - s, xsteps - x};
    endtask
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            rc(RST_A[k], RST_V[k]);
        end
        wr(ANGLE_LIM_OFS, 32'h50);
        rc(ANGLE_LIM_OFS, 32'h50);
        wr(VENC_SCALE_OFS, 32'h320);
        rc(VENC_SCALE_OFS, 32'h320);
        wr(VENC_POS_OFS, 32'h1234);
        rc(VENC_POS_OFS, 32'h1234);
        apb(1'b0, 12'h100, 32'h0);
        check({31'h0, perr}, 32'h1);
        check(rd, 32'h0);
        wr(ERR_OFS, 32'h55);
        rc(ERR_OFS, 32'h0);
        i_src.enc_move(2);
        rc(ENC_POS_OFS, 32'h2);
        wr(ENC_SCALE_OFS, 32'h2_0000);
        i_src.enc_move(1);
        rc(ENC_POS_OFS, 32'h4);
        rc(ERR_OFS, 32'h4);
        wr(PID_DIV_OFS, 32'h9);
        wr(PID_P_OFS, 32'h100);
        wr(SW_OFS_OFS, 32'h64);
        wr(CTRL_OFS, 32'h1);
        repeat (30) @(posedge pclk);
        rc(VEL_OFS, 32'h68);
        wr(VCLIP_OFS, 32'h32);
        repeat (30) @(posedge pclk);
        rc(VEL_OFS, 32'h32);
        rc(CLIP_OFS, 32'h36);
        wr(TOL_OFS, 32'h8);
        repeat (30) @(posedge pclk);
        rc(CLIP_OFS, 32'h32);
        wr(TOL_OFS, 32'h0);
        wr(PID_P_OFS, 32'h0);
        wr(SW_OFS_OFS, 32'h0);
        wr(ICLIP_OFS, 32'h1000);
        wr(PID_I_OFS, 32'h100);
        apb(1'b0, ISUM_OFS, 32'h0);
        v0 = rd;
        // Four integration periods between the two sampling edges
        repeat (509) @(posedge pclk);
        rc(ISUM_OFS, v0 + 32'h10);
        wr(ICLIP_OFS, 32'hA);
        repeat (200) @(posedge pclk);
        rc(ISUM_OFS, 32'hA);
        i_src.enc_move(-4);
        rc(ERR_OFS, 32'hFFFF_FFFC);
        repeat (900) @(posedge pclk);
        rc(ISUM_OFS, 32'hFFFF_FFF6);
        wr(CTRL_OFS, 32'h0);
        wr(FSCALE_OFS, 32'h6000);
        wr(CTRL_OFS, 32'h4);
        d = steps;
        i_src.master_steps(8, 1'b0);
        check(32'(steps - d), 32'h6);
        rc(SEQ_POS_OFS, 32'h6);
        check({31'h0, dir_out}, 32'h0);
        wr(CTRL_OFS, 32'hC);
        i_src.master_steps(8, 1'b0);
        rc(SEQ_POS_OFS, 32'h0);
        check({31'h0, dir_out}, 32'h1);
        wr(VCLIP_OFS, 32'h7FFF_FFFF);
        wr(SW_OFS_OFS, 32'h7FFF_FFFF);
        wr(PID_I_OFS, 32'h0);
        wr(VENC_POS_OFS, 32'h0);
        wr(CTRL_OFS, 32'h3);
        repeat (120) @(posedge pclk);
        rc(SEQ_POS_OFS, 32'h50);
        run();
        check(32'(ds), 32'(d));
        check(32'(dx), 32'h0);
        check({31'h0, d >= 100}, 32'h1);
        wr(XTHR_OFS, 32'h0);
        wr(XDIV_OFS, 32'h4);
        run();
        check(32'(ds), 32'h0);
        check({31'h0, dx * 4 >= d - 3 && dx * 4 <= d + 3}, 32'h1);
        stop_test();
    end
endmodule
